// file: onoff_pkg.sv
package onoff_pkg;
   // ----------------------------------------
   // register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_SWITCH_BAND = 8'h04;
   localparam logic [7:0] ADDR_UPPER_BAND = 8'h08;
   localparam logic [7:0] ADDR_LOWER_BAND = 8'h0C;
   localparam logic [7:0] ADDR_COOL_BAND = 8'h10;
   localparam logic [7:0] ADDR_DEAD_ZONE = 8'h14;
   localparam logic [7:0] ADDR_BIAS = 8'h18;
   localparam logic [7:0] ADDR_PROCESS = 8'h1C;
   localparam logic [7:0] ADDR_SETPOINT = 8'h20;
   localparam logic [7:0] ADDR_COMPUTED = 8'h24;
   localparam logic [7:0] ADDR_POSITION = 8'h28;
   localparam logic [7:0] ADDR_STATUS = 8'h2C;
   localparam logic [7:0] ADDR_BIASED = 8'h30;
   // ----------------------------------------
   // control fields
   // ----------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_TWO_POINT_BIT = 2;
   localparam int CTRL_INTEGRAL_BIT = 3;
   localparam int CTRL_REVERSE_BIT = 4;
   // ----------------------------------------
   // limits and resets, 0.1 % units
   // ----------------------------------------
   localparam logic signed [15:0] BAND_MIN = 16'sh0000;
   localparam logic signed [15:0] BAND_MAX = 16'sh03E8;
   localparam logic signed [15:0] BIAS_MIN = -16'sh0032;
   localparam logic signed [15:0] BIAS_MAX = 16'sh041A;
   localparam logic signed [15:0] HC_DZ_MIN = -16'sh03E8;
   localparam logic signed [15:0] HC_DZ_MAX = 16'sh01F4;
   localparam logic signed [15:0] PP_DZ_MIN = 16'sh000A;
   localparam logic signed [15:0] PP_DZ_MAX = 16'sh0064;
   localparam logic signed [15:0] HC_SPLIT = 16'sh01F4;
   localparam logic signed [15:0] BAND_RST = 16'sh000A;
   localparam logic signed [15:0] DZ_RST = 16'sh0014;
   localparam logic signed [15:0] BIAS_RST = 16'sh01F4;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      MODE_ONOFF,
      MODE_HEAT_COOL,
      MODE_POSITION
   } mode_t;

   typedef struct packed {
      logic heat_on;
      logic cool_on;
      logic direct_on;
      logic reverse_on;
   } drive_t;

   typedef struct packed {
      logic signed [15:0] process_value;
      logic signed [15:0] target_setpoint;
      logic signed [15:0] computed;
      logic signed [15:0] position;
   } sample_t;
endpackage

// file: onoff_deadband_output_logic.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - in on/off mode each output is only fully on or fully off.
// - heating/cooling mode has its own switch band for heat and for cool.
// - two-point mode has upper and lower widths and is refused in heating/cooling mode.
// - the on/off switch band is clamped to 0.0..100.0 % of input span.
// - in heating/cooling or position mode the band is 0.0..100.0 % of output.
// - upper and lower widths are each clamped to 0.0..100.0 % of span.
// - the cooling switch band is clamped to 0.0..100.0 %.
// - the offset bias applies only while integral action is off; position mode compares the unbiased computed value with position.
// - the bias, -5.0..105.0 %, is the output when process equals setpoint.
// - a positive dead zone drives neither heat nor cool inside it.
// - a negative dead zone drives both heat and cool inside the overlap.
// - dead zone is -100.0..50.0 % in heating/cooling and 1.0..10.0 % in position.
// - position mode has a dead zone between relays and hysteresis per relay.
// - a difference inside the dead zone turns no relay on; one already on holds until below dead zone minus band.
// - beyond the dead zone, plus drives direct, minus drives reverse, swapped when the reverse bit is set.
module onoff_deadband_output_logic (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // actuator drive
   output onoff_pkg::drive_t drive
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic signed [15:0] clamp(input logic signed [15:0] v,
         input logic signed [15:0] lo, input logic signed [15:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // hysteresis: on above on_lvl, off below off_lvl, else hold
   function automatic logic hyst(input logic cur, input logic signed [17:0] x,
         input logic signed [17:0] on_lvl, input logic signed [17:0] off_lvl);
      if (x > on_lvl) begin
         hyst = 1'b1;
      end else if (x < off_lvl) begin
         hyst = 1'b0;
      end else begin
         hyst = cur;
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [4:0] ctrl_r, ctrl_nxt;
   logic signed [15:0] band_r, band_nxt;
   logic signed [15:0] upper_r, upper_nxt;
   logic signed [15:0] lower_r, lower_nxt;
   logic signed [15:0] cool_band_r, cool_band_nxt;
   logic signed [15:0] dz_r, dz_nxt;
   logic signed [15:0] bias_r, bias_nxt;
   onoff_pkg::sample_t smp_r, smp_nxt;
   logic [31:0] prdata_nxt;
   onoff_pkg::drive_t drive_nxt;
   onoff_pkg::mode_t mode;
   logic wr_en, rd_en, hit;
   logic two_point;
   logic signed [15:0] wdat;
   logic signed [15:0] band_eff, dz_eff;
   logic signed [17:0] dev, split, diff, out_eff;
   logic signed [17:0] bias_eff;

   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite & clk_en;
   // read data captured at setup, so it stands through the access cycle
   assign rd_en = psel & ~penable & ~pwrite & clk_en;
   assign wdat = pwdata[15:0];
   assign mode = (ctrl_r[1:0] == 2'd1) ? onoff_pkg::MODE_HEAT_COOL :
                 (ctrl_r[1:0] == 2'd2) ? onoff_pkg::MODE_POSITION : onoff_pkg::MODE_ONOFF;
   assign two_point = ctrl_r[onoff_pkg::CTRL_TWO_POINT_BIT]
                      && (mode == onoff_pkg::MODE_ONOFF);

   // ----------------------------------------
   // register writes with range clamps
   // ----------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      band_nxt = band_r;
      upper_nxt = upper_r;
      lower_nxt = lower_r;
      cool_band_nxt = cool_band_r;
      dz_nxt = dz_r;
      bias_nxt = bias_r;
      smp_nxt = smp_r;
      if (wr_en) begin
         case (paddr)
            onoff_pkg::ADDR_CTRL: begin
               ctrl_nxt = pwdata[4:0];
               if (pwdata[1:0] == 2'd3) begin
                  ctrl_nxt[1:0] = 2'd0;
               end
               if (pwdata[1:0] == 2'd1) begin
                  ctrl_nxt[onoff_pkg::CTRL_TWO_POINT_BIT] = 1'b0;
               end
            end
            onoff_pkg::ADDR_SWITCH_BAND:
               band_nxt = clamp(wdat, onoff_pkg::BAND_MIN, onoff_pkg::BAND_MAX);
            onoff_pkg::ADDR_UPPER_BAND:
               upper_nxt = clamp(wdat, onoff_pkg::BAND_MIN, onoff_pkg::BAND_MAX);
            onoff_pkg::ADDR_LOWER_BAND:
               lower_nxt = clamp(wdat, onoff_pkg::BAND_MIN, onoff_pkg::BAND_MAX);
            onoff_pkg::ADDR_COOL_BAND:
               cool_band_nxt = clamp(wdat, onoff_pkg::BAND_MIN, onoff_pkg::BAND_MAX);
            onoff_pkg::ADDR_DEAD_ZONE:
               dz_nxt = clamp(wdat, onoff_pkg::HC_DZ_MIN, onoff_pkg::HC_DZ_MAX);
            onoff_pkg::ADDR_BIAS:
               bias_nxt = clamp(wdat, onoff_pkg::BIAS_MIN, onoff_pkg::BIAS_MAX);
            onoff_pkg::ADDR_PROCESS: smp_nxt.process_value = wdat;
            onoff_pkg::ADDR_SETPOINT: smp_nxt.target_setpoint = wdat;
            onoff_pkg::ADDR_COMPUTED: smp_nxt.computed = wdat;
            onoff_pkg::ADDR_POSITION: smp_nxt.position = wdat;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // output decision
   // ----------------------------------------
   always_comb begin
      // mode-dependent band unit: span in on/off, output elsewhere
      band_eff = clamp(band_r, onoff_pkg::BAND_MIN, onoff_pkg::BAND_MAX);
      if (mode == onoff_pkg::MODE_POSITION) begin
         dz_eff = clamp(dz_r, onoff_pkg::PP_DZ_MIN, onoff_pkg::PP_DZ_MAX);
      end else begin
         dz_eff = clamp(dz_r, onoff_pkg::HC_DZ_MIN, onoff_pkg::HC_DZ_MAX);
      end
      dev = 18'(smp_r.target_setpoint) - 18'(smp_r.process_value);
      if (ctrl_r[onoff_pkg::CTRL_INTEGRAL_BIT]) begin
         bias_eff = 18'sd0;
         out_eff = 18'(smp_r.computed);
      end else begin
         bias_eff = 18'(bias_r);
         out_eff = 18'(smp_r.computed) + bias_eff;
      end
      split = out_eff - 18'(onoff_pkg::HC_SPLIT);
      diff = 18'(smp_r.computed) - 18'(smp_r.position);
      drive_nxt = drive;
      case (mode)
         onoff_pkg::MODE_ONOFF: begin
            if (two_point) begin
               drive_nxt.heat_on = hyst(drive.heat_on, dev, 18'(lower_r),
                                        -18'(upper_r));
            end else begin
               drive_nxt.heat_on = hyst(drive.heat_on, dev, 18'(band_eff) >>> 1,
                                        -(18'(band_eff) >>> 1));
            end
            drive_nxt.cool_on = 1'b0;
            drive_nxt.direct_on = 1'b0;
            drive_nxt.reverse_on = 1'b0;
         end
         onoff_pkg::MODE_HEAT_COOL: begin
            // heat below split minus half zone, cool above plus half zone
            drive_nxt.heat_on = hyst(drive.heat_on, -split,
                                     (18'(dz_eff) >>> 1) + 18'(band_eff),
                                     18'(dz_eff) >>> 1);
            drive_nxt.cool_on = hyst(drive.cool_on, split,
                                     (18'(dz_eff) >>> 1) + 18'(cool_band_r),
                                     18'(dz_eff) >>> 1);
            drive_nxt.direct_on = 1'b0;
            drive_nxt.reverse_on = 1'b0;
         end
         onoff_pkg::MODE_POSITION: begin
            drive_nxt.heat_on = 1'b0;
            drive_nxt.cool_on = 1'b0;
            drive_nxt.direct_on = hyst(drive.direct_on, diff, 18'(dz_eff),
                                       18'(dz_eff) - 18'(band_eff));
            drive_nxt.reverse_on = hyst(drive.reverse_on, -diff, 18'(dz_eff),
                                        18'(dz_eff) - 18'(band_eff));
            if (ctrl_r[onoff_pkg::CTRL_REVERSE_BIT]) begin
               // sides swapped, each relay keeps its own hold state
               drive_nxt.direct_on = hyst(drive.direct_on, -diff, 18'(dz_eff),
                                          18'(dz_eff) - 18'(band_eff));
               drive_nxt.reverse_on = hyst(drive.reverse_on, diff, 18'(dz_eff),
                                           18'(dz_eff) - 18'(band_eff));
            end
            if (drive_nxt.direct_on && drive_nxt.reverse_on) begin
               drive_nxt.direct_on = 1'b0;
               drive_nxt.reverse_on = 1'b0;
            end
         end
         default: drive_nxt = '0;
      endcase
   end

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always_comb begin
      prdata_nxt = prdata;
      hit = 1'b1;
      case (paddr)
         onoff_pkg::ADDR_CTRL: prdata_nxt = {27'h0, ctrl_r};
         onoff_pkg::ADDR_SWITCH_BAND: prdata_nxt = 32'(band_r);
         onoff_pkg::ADDR_UPPER_BAND: prdata_nxt = 32'(upper_r);
         onoff_pkg::ADDR_LOWER_BAND: prdata_nxt = 32'(lower_r);
         onoff_pkg::ADDR_COOL_BAND: prdata_nxt = 32'(cool_band_r);
         onoff_pkg::ADDR_DEAD_ZONE: prdata_nxt = 32'(dz_eff);
         onoff_pkg::ADDR_BIAS: prdata_nxt = 32'(bias_r);
         onoff_pkg::ADDR_PROCESS: prdata_nxt = 32'(smp_r.process_value);
         onoff_pkg::ADDR_SETPOINT: prdata_nxt = 32'(smp_r.target_setpoint);
         onoff_pkg::ADDR_COMPUTED: prdata_nxt = 32'(smp_r.computed);
         onoff_pkg::ADDR_POSITION: prdata_nxt = 32'(smp_r.position);
         onoff_pkg::ADDR_STATUS: prdata_nxt = {28'h0, drive};
         onoff_pkg::ADDR_BIASED: prdata_nxt = 32'(out_eff);
         default: begin
            prdata_nxt = onoff_pkg::UNMAPPED_DATA;
            hit = 1'b0;
         end
      endcase
      if (!rd_en) begin
         prdata_nxt = prdata;
      end
   end
   assign pslverr = psel & penable & ~hit;

   // ----------------------------------------
   // state
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= '0;
         band_r <= onoff_pkg::BAND_RST;
         upper_r <= onoff_pkg::BAND_RST;
         lower_r <= onoff_pkg::BAND_RST;
         cool_band_r <= onoff_pkg::BAND_RST;
         dz_r <= onoff_pkg::DZ_RST;
         bias_r <= onoff_pkg::BIAS_RST;
         smp_r <= '0;
         prdata <= '0;
         drive <= '0;
      end else if (clk_en) begin
         ctrl_r <= ctrl_nxt;
         band_r <= band_nxt;
         upper_r <= upper_nxt;
         lower_r <= lower_nxt;
         cool_band_r <= cool_band_nxt;
         dz_r <= dz_nxt;
         bias_r <= bias_nxt;
         smp_r <= smp_nxt;
         prdata <= prdata_nxt;
         drive <= drive_nxt;
      end
   end
endmodule

// file: onoff_checker.sv
`timescale 1ns/1ps
module onoff_checker (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // drive
   input wire onoff_pkg::drive_t drive
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // bus answers
   // ----------------------------------------
   ready_always_a: assert property (pready)
      else $error("pready low");
   err_access_a: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   err_unmapped_a: assert property (psel && penable && paddr > 8'h30 |-> pslverr)
      else $error("unmapped access without pslverr");
   err_mapped_a: assert property (psel && penable && paddr <= 8'h30 && paddr[1:0] == 2'h0
      |-> !pslverr) else $error("mapped access with pslverr");
   rd_unmapped_a: assert property (psel && !penable && !pwrite && clk_en && paddr > 8'h30
      |=> prdata == 32'h0) else $error("unmapped read not zero");
   rd_hold_a: assert property (!(psel && !penable && !pwrite && clk_en) |=> $stable(prdata))
      else $error("prdata moved without read");
   status_read_a: assert property (psel && !penable && !pwrite && clk_en &&
      paddr == onoff_pkg::ADDR_STATUS |=> prdata[3:0] == $past(drive))
      else $error("status differs from drive");
   // ----------------------------------------
   // drive outputs
   // ----------------------------------------
   drive_freeze_a: assert property (!clk_en |=> $stable(drive))
      else $error("drive moved while disabled");
   relay_excl_a: assert property (!(drive.direct_on && drive.reverse_on))
      else $error("both relays on");
   side_excl_a: assert property (!((drive.heat_on || drive.cool_on) &&
      (drive.direct_on || drive.reverse_on))) else $error("heat cool and relays mixed");
endmodule
bind onoff_deadband_output_logic onoff_checker chk (.mclk(mclk), .rst_b(rst_b),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive));

// file: onoff_actuator_model.sv
`timescale 1ns/1ps
module onoff_actuator_model (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // relay drive
   input wire onoff_pkg::drive_t drive,
   // valve travel
   output logic signed [15:0] valve_pos
);
   // motor opens on direct, closes on reverse
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         valve_pos <= 16'sh0000;
      end else if (drive.direct_on) begin
         valve_pos <= valve_pos + 16'sh0001;
      end else if (drive.reverse_on) begin
         valve_pos <= valve_pos - 16'sh0001;
      end
   end
endmodule

// file: tb_onoff_deadband_output_logic.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t: got %h exp %h", $time, (g), (e)); end end
module tb_onoff_deadband_output_logic;
   logic mclk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   onoff_pkg::drive_t drive;
   logic signed [15:0] valve_pos;
   int bad_count, cmp_count;
   onoff_deadband_output_logic uut (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive));
   onoff_actuator_model valve (.mclk(mclk), .rst_b(rst_b), .drive(drive),
      .valve_pos(valve_pos));
   // ----------------------------------------
   // apb master
   // ----------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      err = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   task automatic step(input logic [7:0] a, input logic [31:0] d, input logic [3:0] e);
      apb(1'b1, a, d);
      apb(1'b0, onoff_pkg::ADDR_STATUS, 32'h0);
      `CHK({rd[3:0], drive}, {e, e})
   endtask
   task test_done;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      bad_count++;
      test_done;
   end
   initial begin
      {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
      clk_en = 1'b1;
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rdchk(onoff_pkg::ADDR_SWITCH_BAND, 32'h0000000A);
      rdchk(onoff_pkg::ADDR_DEAD_ZONE, 32'h00000014);
      rdchk(onoff_pkg::ADDR_BIAS, 32'h000001F4);
      wr(onoff_pkg::ADDR_SWITCH_BAND, 32'h000007D0);
      rdchk(onoff_pkg::ADDR_SWITCH_BAND, 32'h000003E8);
      wr(onoff_pkg::ADDR_COOL_BAND, 32'h000005DC);
      rdchk(onoff_pkg::ADDR_COOL_BAND, 32'h000003E8);
      wr(onoff_pkg::ADDR_UPPER_BAND, 32'hFFFFFFFB);
      rdchk(onoff_pkg::ADDR_UPPER_BAND, 32'h00000000);
      wr(onoff_pkg::ADDR_BIAS, 32'hFFFFFF9C);
      rdchk(onoff_pkg::ADDR_BIAS, 32'hFFFFFFCE);
      wr(onoff_pkg::ADDR_DEAD_ZONE, 32'hFFFFF830);
      rdchk(onoff_pkg::ADDR_DEAD_ZONE, 32'hFFFFFC18);
      rdchk(8'h40, 32'h00000000);
      `CHK(err, 1'b1)
      $display("register test done");
      wr(onoff_pkg::ADDR_SWITCH_BAND, 32'h00000064);
      wr(onoff_pkg::ADDR_SETPOINT, 32'h000001F4);
      step(onoff_pkg::ADDR_PROCESS, 32'h00000190, 4'h8);
      step(onoff_pkg::ADDR_PROCESS, 32'h000001E0, 4'h8);
      step(onoff_pkg::ADDR_PROCESS, 32'h00000230, 4'h0);
      step(onoff_pkg::ADDR_PROCESS, 32'h00000208, 4'h0);
      clk_en <= 1'b0;
      wr(onoff_pkg::ADDR_PROCESS, 32'h00000190);
      clk_en <= 1'b1;
      rdchk(onoff_pkg::ADDR_PROCESS, 32'h00000208);
      wr(onoff_pkg::ADDR_CTRL, 32'h00000004);
      wr(onoff_pkg::ADDR_LOWER_BAND, 32'h0000001E);
      wr(onoff_pkg::ADDR_UPPER_BAND, 32'h00000028);
      step(onoff_pkg::ADDR_PROCESS, 32'h000001CC, 4'h8);
      step(onoff_pkg::ADDR_PROCESS, 32'h00000212, 4'h8);
      step(onoff_pkg::ADDR_PROCESS, 32'h00000226, 4'h0);
      $display("on off test done");
      wr(onoff_pkg::ADDR_CTRL, 32'h0000000D);
      rdchk(onoff_pkg::ADDR_CTRL, 32'h00000009);
      wr(onoff_pkg::ADDR_SWITCH_BAND, 32'h00000014);
      wr(onoff_pkg::ADDR_COOL_BAND, 32'h00000014);
      wr(onoff_pkg::ADDR_DEAD_ZONE, 32'h00000064);
      step(onoff_pkg::ADDR_COMPUTED, 32'h000001F4, 4'h0);
      step(onoff_pkg::ADDR_COMPUTED, 32'h00000190, 4'h8);
      step(onoff_pkg::ADDR_COMPUTED, 32'h00000258, 4'h4);
      wr(onoff_pkg::ADDR_DEAD_ZONE, 32'hFFFFFF9C);
      step(onoff_pkg::ADDR_COMPUTED, 32'h000001F4, 4'hC);
      wr(onoff_pkg::ADDR_CTRL, 32'h00000001);
      wr(onoff_pkg::ADDR_BIAS, 32'h00000064);
      rdchk(onoff_pkg::ADDR_BIASED, 32'h00000258);
      wr(onoff_pkg::ADDR_CTRL, 32'h00000009);
      wr(onoff_pkg::ADDR_BIASED, 32'h00000000);
      rdchk(onoff_pkg::ADDR_BIASED, 32'h000001F4);
      $display("heat cool test done");
      wr(onoff_pkg::ADDR_CTRL, 32'h0000000A);
      wr(onoff_pkg::ADDR_DEAD_ZONE, 32'h00000032);
      step(onoff_pkg::ADDR_POSITION, 32'h000001F4, 4'h0);
      `CHK(valve_pos > 16'sh0000, 1'b1)
      step(onoff_pkg::ADDR_POSITION, 32'h000001B8, 4'h2);
      step(onoff_pkg::ADDR_POSITION, 32'h000001CC, 4'h2);
      step(onoff_pkg::ADDR_POSITION, 32'h000001EA, 4'h0);
      step(onoff_pkg::ADDR_POSITION, 32'h00000230, 4'h1);
      wr(onoff_pkg::ADDR_DEAD_ZONE, 32'h000000C8);
      step(onoff_pkg::ADDR_POSITION, 32'h0000015E, 4'h2);
      step(onoff_pkg::ADDR_CTRL, 32'h0000001A, 4'h1);
      step(onoff_pkg::ADDR_POSITION, 32'h0000019A, 4'h1);
      $display("position test done");
      test_done;
   end
endmodule
